// File: common/sfp_pkg.sv
// Shared constants and types for the status-flag and identification probe.
// Assumes one core clock; every consumer imports the whole package.
package sfp_pkg;

	localparam int FLAGS_W = 32;

	// Bit positions inside processor_flags_word.
	localparam int CF_BIT = 0;
	localparam int PF_BIT = 2;
	localparam int AF_BIT = 4;
	localparam int ZF_BIT = 6;
	localparam int SF_BIT = 7;
	localparam int TF_BIT = 8;
	localparam int IF_BIT = 9;
	localparam int DF_BIT = 10;
	localparam int OF_BIT = 11;
	localparam int IO_PRIVILEGE_LEVEL_LO_BIT = 12;
	localparam int NT_BIT = 14;
	localparam int RSV15_BIT = 15;
	localparam int AC_BIT = 18;
	localparam int ID_BIT = 21;

	localparam logic [FLAGS_W-1:0] FLAGS_RESET = 32'h0000_0000;
	localparam logic [1:0] CPL_KERNEL = 2'h0;

	// Arithmetic flag vector order is {of, sf, zf, af, pf, cf}.
	localparam int AR_OF = 5;
	localparam int AR_SF = 4;
	localparam int AR_ZF = 3;
	localparam int AR_AF = 2;
	localparam int AR_PF = 1;
	localparam int AR_CF = 0;

	// Query selectors served by this probe.
	localparam logic [31:0] LEAF_VENDOR = 32'h0000_0000;
	localparam logic [31:0] LEAF_FEATURES = 32'h0000_0001;
	localparam logic [31:0] MAX_LEAF = 32'h0000_0001;

	typedef enum logic [3:0] {
		SFP_OP_NONE = 4'h0,
		SFP_OP_SUM = 4'h1,
		SFP_OP_SUM_CARRY = 4'h2,
		SFP_OP_AND = 4'h3,
		SFP_OP_BIT_TEST = 4'h4,
		SFP_OP_CLEAR_CARRY = 4'h5,
		SFP_OP_SET_CARRY = 4'h6,
		SFP_OP_FLAGS_SAVE = 4'h7,
		SFP_OP_FLAGS_LOAD = 4'h8,
		SFP_OP_RESTORE = 4'h9,
		SFP_OP_QUERY = 4'hA,
		SFP_OP_BOUND = 4'hB,
		SFP_OP_BYTE_SWAP = 4'hC,
		SFP_OP_CALL = 4'hD,
		SFP_OP_SIGN_EXT = 4'hE
	} sfp_op_e;

	typedef struct packed {
		sfp_op_e op;
		logic [31:0] opa;
		logic [31:0] opb;
	} sfp_req_s;

	typedef struct packed {
		logic [31:0] reg_a;
		logic [31:0] reg_b;
		logic [31:0] reg_c;
		logic [31:0] reg_d;
	} sfp_qres_s;

endpackage : sfp_pkg

// File: design/sfp_flag_alu.sv
// Combinational flag engine: computes arithmetic flags and a write mask.
// Assumes the caller registers both and applies them in one step.
`timescale 1ns/10ps
module sfp_flag_alu
	import sfp_pkg::*;
#(
	parameter int OPW = 32
) (
	input wire sfp_op_e i_op,
	input wire logic [OPW-1:0] i_opa,
	input wire logic [OPW-1:0] i_opb,
	input wire logic i_carry_in,
	output logic [OPW-1:0] o_result,
	output logic [5:0] o_flags,
	output logic [5:0] o_mask
);

	function automatic logic even_parity(input logic [7:0] v);
		even_parity = ~^v;
	endfunction : even_parity

	localparam int IDXW = $clog2(OPW);

	wire logic is_adc = (i_op == SFP_OP_SUM_CARRY);
	wire logic [OPW:0] sum_w = {1'b0, i_opa} + {1'b0, i_opb}
		+ {{OPW{1'b0}}, is_adc & i_carry_in};
	wire logic [OPW-1:0] sres = sum_w[OPW-1:0];
	wire logic [OPW-1:0] ares = i_opa & i_opb;
	wire logic sum_of = (i_opa[OPW-1] == i_opb[OPW-1])
		&& (sres[OPW-1] != i_opa[OPW-1]);
	wire logic sum_af = i_opa[4] ^ i_opb[4] ^ sres[4];
	wire logic [IDXW-1:0] bidx = i_opb[IDXW-1:0];

	always_comb begin
		o_result = i_opa;
		o_flags = 6'h00;
		o_mask = 6'h00;
		unique case (i_op)
			SFP_OP_SUM, SFP_OP_SUM_CARRY: begin
				o_result = sres;
				o_flags = {sum_of, sres[OPW-1], ~|sres, sum_af,
					even_parity(sres[7:0]), sum_w[OPW]};
				o_mask = 6'h3F;
			end
			SFP_OP_AND: begin
				// Auxiliary carry is undefined here; it is simply kept.
				o_result = ares;
				o_flags = {1'b0, ares[OPW-1], ~|ares, 1'b0,
					even_parity(ares[7:0]), 1'b0};
				o_mask = 6'h3B;
			end
			SFP_OP_BIT_TEST: begin
				o_flags = {5'h00, i_opa[bidx]};
				o_mask = 6'h01;
			end
			SFP_OP_CLEAR_CARRY: begin
				o_flags = 6'h00;
				o_mask = 6'h01;
			end
			SFP_OP_SET_CARRY: begin
				o_flags = 6'h01;
				o_mask = 6'h01;
			end
			default: begin
				o_mask = 6'h00;
			end
		endcase
	end

endmodule : sfp_flag_alu

// File: design/sfp_query.sv
// Lookup for the feature query: selector in, four result words out.
// Assumes the caller decides whether the query exists and registers results.
`timescale 1ns/10ps
module sfp_query
	import sfp_pkg::*;
#(
	// Vendor words are arbitrary neutral values.
	parameter logic [31:0] VENDOR_B = 32'h5346_5050,
	parameter logic [31:0] VENDOR_C = 32'h5246_4F42,
	parameter logic [31:0] VENDOR_D = 32'h4543_4F52,
	parameter logic [31:0] FEATURE_D = 32'h0000_0000
) (
	input wire logic [31:0] i_selector,
	output sfp_qres_s o_res
);

	wire logic sel_vendor = (i_selector == LEAF_VENDOR);
	wire logic sel_feat = (i_selector == LEAF_FEATURES);

	// Unserved selectors answer with zeros rather than faulting.
	assign o_res.reg_a = sel_vendor ? MAX_LEAF : 32'h0000_0000;
	assign o_res.reg_b = sel_vendor ? VENDOR_B : 32'h0000_0000;
	assign o_res.reg_c = sel_vendor ? VENDOR_C : 32'h0000_0000;
	assign o_res.reg_d = sel_vendor ? VENDOR_D
		: (sel_feat ? FEATURE_D : 32'h0000_0000);

endmodule : sfp_query

// File: design/sfp_top.sv
// Status-flag register, flag update per instruction class, feature query.
// Assumes one instruction request per valid cycle from the core pipeline.
//
// Overview of operation
// - Feature-query support flag, bit 21, software may set and clear it.
// - Without the query feature, issuing it raises invalid opcode, no result.
// - Selector in accumulator picks info returned in four result registers.
// - Privilege field bits 12-13, nested-task bit 14, reserved bit 15.
// - Real mode: bit 15 reads zero, bits 12-14 keep last loaded value.
// - Protected mode: bit 15 zero, bit 14 loaded, privilege field by level.
// - Privilege field changes only in real mode or at current privilege level zero.
// - Alignment-check flag bit 18 writable; variants without it stay fixed.
// - Modify class follows result; clear and set classes force the flag.
// - Undefined class may leave any value in the flag.
// - Restore class writes back the six arithmetic flags of the previously saved value.
// - Unlisted flags unchanged; bound, swap, call, sign-extend touch nothing.
// - Sum updates six arithmetic flags; sum-with-carry also consumes carry.
// - Conjunction clears overflow and carry; bit test updates only carry.
`timescale 1ns/10ps
module sfp_top
	import sfp_pkg::*;
#(
	parameter int OPW = 32,
	parameter bit HAS_QUERY = 1'b1,
	parameter bit HAS_ALIGN = 1'b1
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_req_valid,
	input wire sfp_req_s i_req,
	input wire logic i_real_mode,
	input wire logic [1:0] i_cpl,
	output logic [FLAGS_W-1:0] o_processor_flags_word,
	output logic [FLAGS_W-1:0] o_save_value,
	output logic [OPW-1:0] o_alu_result,
	output logic o_retire,
	output logic o_invalid_opcode_fault,
	output logic [31:0] o_selector_result_reg_a,
	output logic [31:0] o_selector_result_reg_b,
	output logic [31:0] o_selector_result_reg_c,
	output logic [31:0] o_selector_result_reg_d
);

	generate
		if (OPW != 8 && OPW != 16 && OPW != 32) begin : g_bad_width
			$error("sfp_top: OPW must be 8, 16 or 32");
		end
	endgenerate

	// Two-stage release keeps the reset removal synchronous to the clock.
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	logic [FLAGS_W-1:0] flags_q;
	logic [FLAGS_W-1:0] flags_d;
	logic [FLAGS_W-1:0] saved_q;
	logic [FLAGS_W-1:0] saved_d;
	logic [OPW-1:0] alu_res_q;
	logic retire_q;
	logic fault_q;
	sfp_qres_s qres_q;
	sfp_qres_s qres_d;

	wire sfp_op_e op = i_req.op;
	wire logic go = i_req_valid && (op != SFP_OP_NONE);
	wire logic [OPW-1:0] opa_w = i_req.opa[OPW-1:0];
	wire logic [OPW-1:0] opb_w = i_req.opb[OPW-1:0];

	logic [OPW-1:0] alu_res;
	logic [5:0] alu_flags;
	logic [5:0] alu_mask;

	sfp_flag_alu #(
		.OPW(OPW)
	) u_alu (
		.i_op(op),
		.i_opa(opa_w),
		.i_opb(opb_w),
		.i_carry_in(flags_q[CF_BIT]),
		.o_result(alu_res),
		.o_flags(alu_flags),
		.o_mask(alu_mask)
	);

	sfp_qres_s qres_w;

	sfp_query u_query (
		.i_selector(i_req.opa),
		.o_res(qres_w)
	);

	// Mapping between the six-bit arithmetic vector and the flag word.
	function automatic logic [FLAGS_W-1:0] arith_to_word(
		input logic [5:0] v);
		logic [FLAGS_W-1:0] w;
		w = '0;
		w[OF_BIT] = v[AR_OF];
		w[SF_BIT] = v[AR_SF];
		w[ZF_BIT] = v[AR_ZF];
		w[AF_BIT] = v[AR_AF];
		w[PF_BIT] = v[AR_PF];
		w[CF_BIT] = v[AR_CF];
		arith_to_word = w;
	endfunction : arith_to_word

	// Merged word for the arithmetic classes; bits outside the mask keep old values.
	wire logic [FLAGS_W-1:0] ar_mask_w = arith_to_word(alu_mask);
	wire logic [FLAGS_W-1:0] ar_val_w = arith_to_word(alu_flags);
	wire logic [FLAGS_W-1:0] arith_next =
		(flags_q & ~ar_mask_w) | (ar_val_w & ar_mask_w);

	// Restore brings back the arithmetic flags held at the last save.
	wire logic [FLAGS_W-1:0] ar_all_w = arith_to_word(6'h3F);
	wire logic [FLAGS_W-1:0] restore_next =
		(flags_q & ~ar_all_w) | (saved_q & ar_all_w);

	// Privilege field is writable in real mode or at level zero only.
	wire logic io_privilege_level_wr_ok = i_real_mode || (i_cpl == CPL_KERNEL);
	wire logic [1:0] io_privilege_level_q = flags_q[IO_PRIVILEGE_LEVEL_LO_BIT+1:IO_PRIVILEGE_LEVEL_LO_BIT];
	// Interrupt flag follows the load only when the level permits it.
	wire logic if_wr_ok = i_real_mode || (i_cpl <= io_privilege_level_q);

	// Bits the load may change unconditionally.
	localparam logic [FLAGS_W-1:0] LOAD_FREE_MASK = 32'h0000_4DD5;

	logic [FLAGS_W-1:0] load_mask;
	always_comb begin
		load_mask = LOAD_FREE_MASK;
		load_mask[NT_BIT] = 1'b1;
		load_mask[IO_PRIVILEGE_LEVEL_LO_BIT] = io_privilege_level_wr_ok;
		load_mask[IO_PRIVILEGE_LEVEL_LO_BIT+1] = io_privilege_level_wr_ok;
		load_mask[IF_BIT] = if_wr_ok;
		load_mask[AC_BIT] = HAS_ALIGN;
		load_mask[ID_BIT] = HAS_QUERY;
		load_mask[RSV15_BIT] = 1'b0;
	end

	wire logic [FLAGS_W-1:0] load_next =
		(flags_q & ~load_mask) | (i_req.opb & load_mask);

	wire logic is_arith = (op == SFP_OP_SUM) || (op == SFP_OP_SUM_CARRY)
		|| (op == SFP_OP_AND) || (op == SFP_OP_BIT_TEST)
		|| (op == SFP_OP_CLEAR_CARRY) || (op == SFP_OP_SET_CARRY);
	wire logic is_query = (op == SFP_OP_QUERY);
	wire logic query_ok = go && is_query && HAS_QUERY;
	wire logic query_bad = go && is_query && !HAS_QUERY;

	always_comb begin
		flags_d = flags_q;
		if (go) begin
			unique case (op)
				SFP_OP_FLAGS_LOAD: flags_d = load_next;
				SFP_OP_RESTORE: flags_d = restore_next;
				default: flags_d = is_arith ? arith_next : flags_q;
			endcase
		end
		// Reserved bit 15 never holds a one in either mode.
		flags_d[RSV15_BIT] = 1'b0;
	end

	assign saved_d = (go && op == SFP_OP_FLAGS_SAVE) ? flags_q : saved_q;
	assign qres_d = query_ok ? qres_w : qres_q;

	// Each instruction commits its full flag word in a single edge.
	always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			flags_q <= FLAGS_RESET;
			saved_q <= FLAGS_RESET;
			retire_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			saved_q <= saved_d;
			retire_q <= go;
			fault_q <= query_bad;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			alu_res_q <= '0;
			qres_q <= '0;
		end else begin
			alu_res_q <= (go && is_arith) ? alu_res : alu_res_q;
			qres_q <= qres_d;
		end
	end

	assign o_processor_flags_word = flags_q;
	assign o_save_value = saved_q;
	assign o_alu_result = alu_res_q;
	assign o_retire = retire_q;
	assign o_invalid_opcode_fault = fault_q;
	assign o_selector_result_reg_a = qres_q.reg_a;
	assign o_selector_result_reg_b = qres_q.reg_b;
	assign o_selector_result_reg_c = qres_q.reg_c;
	assign o_selector_result_reg_d = qres_q.reg_d;

endmodule : sfp_top

// File: tb/sfp_top_checker.sv
// Port-level assertions for the status-flag block.
// Assumes no request is made until the internal reset has lifted.
`timescale 1ns/10ps
module sfp_top_checker
	import sfp_pkg::*;
#(
	parameter bit HAS_QUERY = 1'b1,
	parameter bit HAS_ALIGN = 1'b1
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_req_valid,
	input wire sfp_req_s i_req,
	input wire logic i_real_mode,
	input wire logic [1:0] i_cpl,
	input wire logic [FLAGS_W-1:0] o_processor_flags_word,
	input wire logic [FLAGS_W-1:0] o_save_value,
	input wire logic o_retire,
	input wire logic o_invalid_opcode_fault,
	input wire logic [31:0] o_selector_result_reg_a
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic acc = i_req_valid && (i_req.op != SFP_OP_NONE);
	wire sfp_op_e op = i_req.op;
	AST_RET: assert property (acc |=> o_retire)
		else $error("retire missing after an accepted op");
	AST_IDLE: assert property (!acc |=> !o_retire
		&& $stable(o_processor_flags_word))
		else $error("activity without an accepted op");
	AST_FLT: assert property (o_invalid_opcode_fault |-> !HAS_QUERY
		&& $past(acc && op == SFP_OP_QUERY))
		else $error("fault without an unsupported query");
	AST_R15: assert property (!o_processor_flags_word[RSV15_BIT])
		else $error("reserved bit 15 set");
	AST_IO_PRIVILEGE_LEVEL: assert property (acc && !i_real_mode && i_cpl != CPL_KERNEL
		|=> $stable(o_processor_flags_word[13:12]))
		else $error("privilege field changed at nonzero level");
	AST_KEEP: assert property (acc && op inside {SFP_OP_BOUND,
		SFP_OP_BYTE_SWAP, SFP_OP_CALL, SFP_OP_SIGN_EXT}
		|=> $stable(o_processor_flags_word))
		else $error("flag-neutral op changed flags");
	AST_CARRY: assert property (acc && op inside {SFP_OP_CLEAR_CARRY,
		SFP_OP_SET_CARRY} |=> o_processor_flags_word[CF_BIT]
		== $past(op == SFP_OP_SET_CARRY))
		else $error("carry not forced");
	AST_SAVE: assert property (acc && op == SFP_OP_FLAGS_SAVE
		|=> o_save_value == $past(o_processor_flags_word))
		else $error("saved word differs");
	AST_QRY: assert property (!(acc && op == SFP_OP_QUERY && HAS_QUERY)
		|=> $stable(o_selector_result_reg_a))
		else $error("query result changed without a query");
	AST_ALN: assert property (!HAS_ALIGN |-> !o_processor_flags_word[AC_BIT])
		else $error("alignment flag set on variant without it");
endmodule : sfp_top_checker

bind sfp_top sfp_top_checker #(.HAS_QUERY(HAS_QUERY), .HAS_ALIGN(HAS_ALIGN))
	u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_req_valid(i_req_valid), .i_req(i_req), .i_real_mode(i_real_mode),
	.i_cpl(i_cpl), .o_processor_flags_word(o_processor_flags_word),
	.o_save_value(o_save_value), .o_retire(o_retire),
	.o_invalid_opcode_fault(o_invalid_opcode_fault),
	.o_selector_result_reg_a(o_selector_result_reg_a));

// File: tb/tb_sfp_top.sv
// Self-checking bench with a flag model; a reduced variant runs alongside.
// Assumes the default 32-bit operand width.
`timescale 1ns/10ps
module tb_sfp_top;
	import sfp_pkg::*;
	logic clk, rst_n, vld, rm, ret, flt, flt2, m_ret, m_flt, chk, alu_v;
	logic [1:0] current_privilege_level;
	sfp_req_s req;
	logic [31:0] fl, sv, alu, qa, fl2, qa2, m_fl, m_sv, m_alu, m_qa, dc, svdc;
	logic [31:0] qb, qc, qd, m_qb, m_qc, m_qd;
	logic [31:0] rnd;
	int n_errors, num_checks;
	sfp_top dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_req_valid(vld),
		.i_req(req), .i_real_mode(rm), .i_cpl(current_privilege_level),
		.o_processor_flags_word(fl), .o_save_value(sv), .o_alu_result(alu),
		.o_retire(ret), .o_invalid_opcode_fault(flt),
		.o_selector_result_reg_a(qa), .o_selector_result_reg_b(qb),
		.o_selector_result_reg_c(qc), .o_selector_result_reg_d(qd));
	sfp_top #(.HAS_QUERY(1'b0), .HAS_ALIGN(1'b0)) dut_lite (.i_ref_clk(clk),
		.i_rst_n(rst_n), .i_req_valid(vld), .i_req(req), .i_real_mode(rm),
		.i_cpl(current_privilege_level), .o_processor_flags_word(fl2), .o_save_value(),
		.o_alu_result(), .o_retire(), .o_invalid_opcode_fault(flt2),
		.o_selector_result_reg_a(qa2), .o_selector_result_reg_b(),
		.o_selector_result_reg_c(), .o_selector_result_reg_d());

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic [31:0] spread(input logic [5:0] v);
		return {20'h0, v[5], 3'h0, v[4], v[3], 1'h0, v[2], 1'h0, v[1], 1'h0, v[0]};
	endfunction : spread

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	// Called just after a rising edge; the op is taken at the next edge.
	task automatic issue(input sfp_op_e op, input logic [31:0] a, b);
		logic [32:0] s;
		logic [31:0] r, x, m;
		logic [5:0] v, msk, udc;
		vld <= 1'b1;
		req <= '{op, a, b};
		@(posedge clk);
		chk = 1'b1;
		m_ret = (op != SFP_OP_NONE);
		m_flt = (op == SFP_OP_QUERY);
		v = '0; msk = '0; udc = '0; alu_v = 1'b0;
		case (op)
			SFP_OP_SUM, SFP_OP_SUM_CARRY: begin
				s = {1'b0, a} + {1'b0, b}
					+ {32'h0, op == SFP_OP_SUM_CARRY && m_fl[CF_BIT]};
				r = s[31:0]; x = a ^ b ^ r;
				v = {a[31] == b[31] && r[31] != a[31], r[31], r == 32'h0,
					x[4], ~^r[7:0], s[32]};
				msk = 6'h3F; m_alu = r; alu_v = 1'b1;
			end
			SFP_OP_AND: begin
				r = a & b;
				v = {1'b0, r[31], r == 32'h0, 1'b0, ~^r[7:0], 1'b0};
				msk = 6'h3B; udc = 6'h04; m_alu = r; alu_v = 1'b1;
			end
			SFP_OP_BIT_TEST: begin v[0] = a[b[4:0]]; msk = 6'h01; udc = 6'h3E; end
			SFP_OP_CLEAR_CARRY: msk = 6'h01;
			SFP_OP_SET_CARRY: begin v = 6'h01; msk = 6'h01; end
			SFP_OP_RESTORE: begin
				v = {m_sv[11], m_sv[7], m_sv[6], m_sv[4], m_sv[2], m_sv[0]};
				udc = {svdc[11], svdc[7], svdc[6], svdc[4], svdc[2], svdc[0]};
				msk = 6'h3F;
			end
			SFP_OP_FLAGS_SAVE: begin m_sv = m_fl; svdc = dc; end
			SFP_OP_FLAGS_LOAD: begin
				m = 32'h0024_4DD5 | ((rm || current_privilege_level == 2'h0) ? 32'h0000_3000 : 32'h0)
					| ((rm || current_privilege_level <= m_fl[13:12]) ? 32'h0000_0200 : 32'h0);
				m_fl = (m_fl & ~m) | (b & m); dc = dc & ~m;
			end
			SFP_OP_QUERY: begin
				// Vendor words are arbitrary, so the instance's own settings
				// are the only reference for them.
				m_qa = (a == 32'h0) ? 32'h1 : 32'h0;
				m_qb = (a == 32'h0) ? dut.u_query.VENDOR_B : 32'h0;
				m_qc = (a == 32'h0) ? dut.u_query.VENDOR_C : 32'h0;
				m_qd = (a == 32'h0) ? dut.u_query.VENDOR_D
					: ((a == 32'h1) ? dut.u_query.FEATURE_D : 32'h0);
			end
			default: ;
		endcase
		m_fl = (m_fl & ~spread(msk)) | spread(v & msk);
		dc = (dc & ~spread(msk | udc)) | spread(udc);
	endtask : issue

	// Undefined flags are masked out of every comparison.
	always @(negedge clk) begin
		if (chk) begin
			check(fl & ~dc, m_fl & ~dc);
			check(fl2 & ~dc, m_fl & ~dc & 32'hFFDB_FFFF);
			check(sv & ~svdc, m_sv & ~svdc);
			check(qa, m_qa);
			check(qb, m_qb);
			check(qc, m_qc);
			check(qd, m_qd);
			check(qa2, 32'h0);
			check({31'h0, ret}, {31'h0, m_ret});
			check({31'h0, flt2}, {31'h0, m_flt});
			check({31'h0, flt}, 32'h0);
			if (alu_v) check(alu, m_alu);
		end
	end

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		#50000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		rst_n = 1'b0; vld = 1'b0; rm = 1'b0; current_privilege_level = 2'h0; req = '0; chk = 1'b0;
		m_fl = '0; m_sv = '0; m_qa = '0; m_alu = '0; dc = '0; svdc = '0;
		m_qb = '0;
		m_qc = '0;
		m_qd = '0;
		rnd = 32'h0000_0059;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		issue(SFP_OP_SUM, 32'h1, 32'hFFFF_FFFF);
		issue(SFP_OP_SUM_CARRY, 32'h7FFF_FFFF, 32'h0);
		current_privilege_level <= 2'h3;
		issue(SFP_OP_FLAGS_LOAD, 32'h0, 32'hFFFF_FFFF);
		current_privilege_level <= 2'h0;
		issue(SFP_OP_FLAGS_LOAD, 32'h0, 32'hFFFF_FFFF);
		issue(SFP_OP_FLAGS_LOAD, 32'h0, 32'h0);
		for (int i = 0; i < 3; i++) issue(SFP_OP_QUERY, 32'(i), 32'h0);
		for (int i = 0; i < 400; i++) begin
			rnd = lfsr(rnd);
			rm <= rnd[0];
			current_privilege_level <= rnd[2:1];
			issue(sfp_op_e'(rnd[6:3] % 4'hF), lfsr(rnd), rnd ^ 32'h5A5A_0000);
		end
		vld <= 1'b0;
		@(posedge clk);
		m_ret = 1'b0;
		// A query as the last random op would otherwise leave a stale fault.
		m_flt = 1'b0;
		@(posedge clk);
		report_and_stop();
	end
endmodule : tb_sfp_top
